// >>> logic/rpm_pkg.sv
// rpm_pkg: register map, field positions and timing constants for the
// receive-port status monitor. Assumes an 8-bit register port inside the
// device and a 125 MHz system clock.
// Functional notes
// - lock change and control-channel faults clear on read
// - count parity errors into 16-bit high/low counter
// - parity fault flag at programmed error threshold
// - counter read clears counter and parity fault
// - interrupt request on parity fault when enabled
// - lock loss clears parity counter and flag by default
// - encoding or sequence error latches encoder fault bit
// - interrupt request on encoder fault when enabled
// - encoder fault needs fault counting, threshold above one
// - encoder fault flag clears on read
// - failed CRC packets do not update link information while CRC checking is on
// - frequency steady and clock missing in status two
// - clock missing when frequency below low threshold
// - steady drops when change exceeds hysteresis
// - measured frequency shown in two readout registers
// - interrupt request on frequency change when enabled
// - count lines per frame, packet or strobe mode
// - line count held from interrupt until read
// - last line byte length, held on interrupt
// - relay sensor status, rise/fall flags clear on read
package rpm_pkg;
	// register offsets
	localparam logic [7:0] RPM_GEN_CFG   = 8'h02;
	localparam logic [7:0] RPM_CRC_CAP   = 8'h4A;
	localparam logic [7:0] RPM_IRQ_EN    = 8'h4B;
	localparam logic [7:0] RPM_STS_ONE   = 8'h4D;
	localparam logic [7:0] RPM_STS_TWO   = 8'h4E;
	localparam logic [7:0] RPM_FREQ_HI   = 8'h4F;
	localparam logic [7:0] RPM_FREQ_LO   = 8'h50;
	localparam logic [7:0] RPM_SENS_A    = 8'h51;
	localparam logic [7:0] RPM_PAR_HI    = 8'h55;
	localparam logic [7:0] RPM_PAR_LO    = 8'h56;
	localparam logic [7:0] RPM_DP_ONE    = 8'h59;
	localparam logic [7:0] RPM_DP_TWO    = 8'h5A;
	localparam logic [7:0] RPM_SER_ID    = 8'h5B;
	localparam logic [7:0] RPM_PAR_THR   = 8'h5C;
	localparam logic [7:0] RPM_LCNT_HI   = 8'h73;
	localparam logic [7:0] RPM_LCNT_LO   = 8'h74;
	localparam logic [7:0] RPM_LLEN_HI   = 8'h75;
	localparam logic [7:0] RPM_LLEN_LO   = 8'h76;
	localparam logic [7:0] RPM_FREQ_CTL  = 8'h77;
	localparam logic [7:0] RPM_LFLT_CTL  = 8'hB9;
	localparam logic [7:0] RPM_CRC_CTL   = 8'hBA;
	localparam logic [7:0] RPM_SENS_RISE = 8'hDC;
	localparam logic [7:0] RPM_SENS_FALL = 8'hDD;
	// field positions
	localparam int RPM_B_PAR_EN   = 0;  // general cfg: parity check on
	localparam int RPM_B_KEEP_PAR = 1;  // general cfg: keep count on unlock
	localparam int RPM_B_RAW_MODE = 2;  // general cfg: raw line strobes
	localparam int RPM_B_CRC_CAP  = 4;  // crc capable flag
	localparam int RPM_B_CRC_DIS  = 7;  // crc disable
	localparam int RPM_B_LF_EN    = 3;  // link fault counting enable
	localparam int RPM_B_LOCKCHG  = 0;  // status one
	localparam int RPM_B_PARFLT   = 1;
	localparam int RPM_B_CCCRC    = 2;
	localparam int RPM_B_CCSEQ    = 3;
	localparam int RPM_B_LOCK     = 4;
	localparam int RPM_B_NOCLK    = 1;  // status two
	localparam int RPM_B_STEADY   = 2;
	localparam int RPM_B_FCHG     = 3;
	localparam int RPM_B_ENCFLT   = 5;
	localparam int RPM_B_LCCHG    = 6;
	localparam int RPM_B_LLCHG    = 7;
	// irq enable bits: parity, encoder, freq, lines, length, sensor
	localparam int RPM_IRQ_W      = 6;
	// reset values
	localparam logic [7:0] RPM_GEN_CFG_RST  = 8'h01;
	localparam logic [7:0] RPM_CRC_CTL_RST  = 8'h80;
	localparam logic [7:0] RPM_PAR_THR_RST  = 8'h01;
	localparam logic [7:0] RPM_FREQ_CTL_RST = 8'h25;
	localparam logic [7:0] RPM_LFLT_CTL_RST = 8'h00;
	// frequency window: 256 us gives MHz in 8.8 fixed point
	localparam int RPM_SYS_CLK_MHZ  = 125;
	localparam int RPM_FREQ_WIN_US  = 256;
	localparam int RPM_FREQ_WIN_CYC = RPM_FREQ_WIN_US * RPM_SYS_CLK_MHZ;
	// link information word indices
	localparam logic [2:0] RPM_INFO_DP_ONE = 3'h4;
	localparam logic [2:0] RPM_INFO_DP_TWO = 3'h5;
	localparam logic [2:0] RPM_INFO_SER_ID = 3'h6;
endpackage : rpm_pkg

// >>> logic/rpm_xfer_if.sv
// rpm_xfer_if: carries link-domain toggles and held words to the system
// domain, and system levels to the link domain. Toggles mark events;
// each word stays still until its next toggle.
interface rpm_xfer_if;
	logic [3:0]  evt_tgl;   // parity, encoder, cc crc, cc sequence
	logic        clk_tgl;   // flips every link clock
	logic        frm_tgl;   // new frame counts ready
	logic [15:0] line_cnt;  // lines in last frame
	logic [15:0] line_byte_length;  // bytes in last line
	logic        info_tgl;  // new link information word
	logic [11:0] info_word; // crc_ok, index[2:0], data[7:0]
	logic        raw_mode;  // system level: raw line strobe mode
	logic        ce;        // system level: clock enable
	modport link (output evt_tgl, clk_tgl, frm_tgl, line_cnt, line_byte_length,
		info_tgl, info_word, input raw_mode, ce);
	modport core (input evt_tgl, clk_tgl, frm_tgl, line_cnt, line_byte_length,
		info_tgl, info_word, output raw_mode, ce);
endinterface : rpm_xfer_if

// >>> logic/rpm_link_side.sv
// rpm_link_side: link-clock logic; turns link events into toggles and
// counts lines and bytes. Assumes all data inputs are on link_clk_i.
module rpm_link_side
	import rpm_pkg::*;
(
	input  wire logic       link_clk_i,  // recovered link clock
	input  wire logic       sys_rst_i,   // system reset, resynced here
	input  wire logic [3:0] evt_i,       // one-cycle error pulses
	input  wire logic       frame_start_i,
	input  wire logic       line_valid_strobe_i,
	input  wire logic       long_pkt_i,  // one pulse per long packet
	input  wire logic       byte_valid_i,
	input  wire logic       info_valid_i,
	input  wire logic [2:0] info_idx_i,
	input  wire logic [7:0] info_data_i,
	input  wire logic       info_crc_ok_i,
	rpm_xfer_if.link        xf
);
	logic [2:0]  rst_s;           // reset and level synchronisers
	logic [1:0]  ce_s, raw_s;
	logic        lv_d_r;          // last line strobe
	logic [15:0] lines_r, bytes_r;
	logic        line_start;
	logic        rst, ce;

	// levels from the system side pass two flops first, reset three
	always_ff @(posedge link_clk_i) begin
		rst_s <= {rst_s[1:0], sys_rst_i};
		ce_s  <= {ce_s[0], xf.ce};
		raw_s <= {raw_s[0], xf.raw_mode};
	end
	assign rst = rst_s[2];
	assign ce  = ce_s[1];

	// raw mode counts strobe rises, packet mode counts long packets
	assign line_start = raw_s[1] ? (line_valid_strobe_i & ~lv_d_r)
		: long_pkt_i;

	// event toggles and a clock toggle for frequency
	always_ff @(posedge link_clk_i) begin
		if (rst) begin
			xf.evt_tgl <= 4'h0;
			xf.clk_tgl <= 1'b0;
		end else if (ce) begin
			xf.evt_tgl <= xf.evt_tgl ^ evt_i;
			xf.clk_tgl <= ~xf.clk_tgl;
		end
	end

	// line and byte counting; totals are held until the next frame
	always_ff @(posedge link_clk_i) begin
		if (rst) begin
			lv_d_r <= 1'b0; lines_r <= 16'h0000; bytes_r <= 16'h0000;
			xf.line_cnt <= 16'h0000; xf.line_byte_length <= 16'h0000;
			xf.frm_tgl <= 1'b0;
		end else if (ce) begin
			lv_d_r <= line_valid_strobe_i;
			if (frame_start_i) begin
				xf.line_cnt <= lines_r;
				xf.line_byte_length <= bytes_r;
				xf.frm_tgl  <= ~xf.frm_tgl;
				lines_r <= 16'h0000;
				bytes_r <= 16'h0000;
			end else if (line_start) begin
				lines_r <= lines_r + 16'h0001;
				bytes_r <= {15'h0000, byte_valid_i};   // restart length
			end else if (byte_valid_i) begin
				bytes_r <= bytes_r + 16'h0001;
			end
		end
	end

	// link information words
	always_ff @(posedge link_clk_i) begin
		if (rst) begin
			xf.info_tgl  <= 1'b0;
			xf.info_word <= 12'h000;
		end else if (ce && info_valid_i) begin
			xf.info_word <= {info_crc_ok_i, info_idx_i, info_data_i};
			xf.info_tgl  <= ~xf.info_tgl;
		end
	end
endmodule : rpm_link_side

// >>> logic/rpm_port_monitor.sv
// rpm_port_monitor: system-domain status registers of one receive port.
// Assumes an internal 8-bit register port (one-cycle strobes) and link
// events arriving on link_clk_i from the deserializer front end.
module rpm_port_monitor
	import rpm_pkg::*;
#(
	parameter int FREQ_WIN_CYC = RPM_FREQ_WIN_CYC  // measure window
) (
	input  wire logic       sys_clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       ce_i,           // freezes all state but the link-side synchronisers when low
	input  wire logic       link_clk_i,
	input  wire logic       lock_i,         // receiver lock, async level
	input  wire logic [3:0] link_evt_i,     // parity, enc/seq, cc crc/seq
	input  wire logic       frame_start_i,
	input  wire logic       line_valid_strobe_i,
	input  wire logic       long_pkt_i,
	input  wire logic       byte_valid_i,
	input  wire logic       info_valid_i,
	input  wire logic [2:0] info_idx_i,
	input  wire logic [7:0] info_data_i,
	input  wire logic       info_crc_ok_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	output logic            irq_req_o
);
	initial begin
		if (FREQ_WIN_CYC < 1 || FREQ_WIN_CYC > 65535)
			$error("FREQ_WIN_CYC out of range");
	end

	rpm_xfer_if xf ();

	// link domain front end
	rpm_link_side u_link (
		.link_clk_i          (link_clk_i),
		.sys_rst_i           (sys_rst_i),
		.evt_i               (link_evt_i),
		.frame_start_i       (frame_start_i),
		.line_valid_strobe_i (line_valid_strobe_i),
		.long_pkt_i          (long_pkt_i),
		.byte_valid_i        (byte_valid_i),
		.info_valid_i        (info_valid_i),
		.info_idx_i          (info_idx_i),
		.info_data_i         (info_data_i),
		.info_crc_ok_i       (info_crc_ok_i),
		.xf                  (xf)
	);

	// software registers
	logic [7:0]  gen_cfg_r, crc_cap_r, irq_en_r, par_thr_r;
	logic [7:0]  freq_ctl_r, lflt_ctl_r, crc_ctl_r;
	logic [7:0]  sens_r [4];          // sensor diagnostic a..d
	logic [7:0]  dp_one_r, dp_two_r, ser_id_r;
	logic [7:0]  rise_r, fall_r;      // sensor edge flags
	// status state
	logic        lockchg_r, parflt_r, cccrc_r, ccseq_r, encflt_r;
	logic        noclk_r, steady_r, fchg_r, lcchg_r, llchg_r;
	logic [15:0] par_cnt_r;
	logic [7:0]  par_lo_hold_r;       // low byte caught at high read
	logic [15:0] freq_r, win_cnt_r, edge_cnt_r;
	logic [15:0] lcnt_r, llen_r;
	logic [7:0]  rdata_nxt;

	// crossing synchronisers
	logic [7:0] tg_s1, tg_s2, tg_s3;
	logic [7:0] tg_in, tg_ev;
	logic [1:0] lock_s;
	logic       lock_d_r;
	assign tg_in = {xf.info_tgl, xf.frm_tgl, xf.clk_tgl, 1'b0, xf.evt_tgl};
	assign tg_ev = tg_s2 ^ tg_s3;
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			tg_s1 <= 8'h00; tg_s2 <= 8'h00; tg_s3 <= 8'h00;
			lock_s <= 2'b00; lock_d_r <= 1'b0;
		end else if (ce_i) begin
			tg_s1 <= tg_in; tg_s2 <= tg_s1; tg_s3 <= tg_s2;
			lock_s <= {lock_s[0], lock_i}; lock_d_r <= lock_s[1];
		end
	end
	assign xf.raw_mode = gen_cfg_r[RPM_B_RAW_MODE];
	assign xf.ce       = ce_i;

	// register hit on a read or write strobe
	function automatic logic hit(input logic stb, input logic [7:0] off);
		return stb && (reg_addr_i == off);
	endfunction

	// decoded events
	logic par_ev, enc_ev, ccc_ev, ccs_ev, clk_ev, frm_ev, info_ev;
	logic lock_now, lock_lost, lock_chg, crc_on, enc_rep, info_take;
	logic [2:0] info_idx;
	logic [7:0] info_dat;
	assign par_ev  = tg_ev[0] & gen_cfg_r[RPM_B_PAR_EN];
	assign enc_ev  = tg_ev[1];
	assign ccc_ev  = tg_ev[2];
	assign ccs_ev  = tg_ev[3];
	assign clk_ev  = tg_ev[5];
	assign frm_ev  = tg_ev[6];
	assign info_ev = tg_ev[7];
	assign lock_now  = lock_s[1];
	assign lock_chg  = lock_now ^ lock_d_r;
	assign lock_lost = lock_d_r & ~lock_now;
	// enc faults only reported with fault counting and threshold above one
	assign enc_rep = enc_ev & lflt_ctl_r[RPM_B_LF_EN]
		& (lflt_ctl_r[2:0] > 3'd1);
	assign crc_on  = ~crc_ctl_r[RPM_B_CRC_DIS] & crc_cap_r[RPM_B_CRC_CAP];
	assign info_idx  = xf.info_word[10:8];
	assign info_dat  = xf.info_word[7:0];
	assign info_take = info_ev & (~crc_on | xf.info_word[11]);

	// writable configuration and datapath control words
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			gen_cfg_r  <= RPM_GEN_CFG_RST;  crc_cap_r <= 8'h00;
			irq_en_r   <= 8'h00;            par_thr_r <= RPM_PAR_THR_RST;
			freq_ctl_r <= RPM_FREQ_CTL_RST; lflt_ctl_r <= RPM_LFLT_CTL_RST;
			crc_ctl_r  <= RPM_CRC_CTL_RST;
			dp_one_r   <= 8'h00;            dp_two_r  <= 8'h00;
		end else if (ce_i) begin
			if (hit(reg_wr_i, RPM_GEN_CFG))  gen_cfg_r  <= reg_wdata_i;
			if (hit(reg_wr_i, RPM_CRC_CAP))  crc_cap_r  <= reg_wdata_i;
			if (hit(reg_wr_i, RPM_IRQ_EN))   irq_en_r   <= reg_wdata_i;
			if (hit(reg_wr_i, RPM_PAR_THR))  par_thr_r  <= reg_wdata_i;
			if (hit(reg_wr_i, RPM_FREQ_CTL)) freq_ctl_r <= reg_wdata_i;
			if (hit(reg_wr_i, RPM_LFLT_CTL)) lflt_ctl_r <= reg_wdata_i;
			if (hit(reg_wr_i, RPM_CRC_CTL))  crc_ctl_r  <= reg_wdata_i;
			// a link update in the same cycle overrides the write
			if (hit(reg_wr_i, RPM_DP_ONE))   dp_one_r   <= reg_wdata_i;
			if (info_take && info_idx == RPM_INFO_DP_ONE)
				dp_one_r <= info_dat;
			if (hit(reg_wr_i, RPM_DP_TWO))   dp_two_r   <= reg_wdata_i;
			if (info_take && info_idx == RPM_INFO_DP_TWO)
				dp_two_r <= info_dat;
		end
	end

	// sensor status relay, serializer id and sensor edge flags
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 4; i++) sens_r[i] <= 8'h00;
			ser_id_r <= 8'h00; rise_r <= 8'h00; fall_r <= 8'h00;
		end else if (ce_i) begin
			// clear on read, but a fresh edge in the same cycle stays
			if (hit(reg_rd_i, RPM_SENS_RISE)) rise_r <= 8'h00;
			if (hit(reg_rd_i, RPM_SENS_FALL)) fall_r <= 8'h00;
			if (info_take && !info_idx[2]) begin
				sens_r[info_idx[1:0]] <= info_dat;
				if (info_idx[1:0] == 2'd0) begin
					rise_r <= (hit(reg_rd_i, RPM_SENS_RISE) ? 8'h00 : rise_r)
						| (info_dat & ~sens_r[0]);
					fall_r <= (hit(reg_rd_i, RPM_SENS_FALL) ? 8'h00 : fall_r)
						| (~info_dat & sens_r[0]);
				end
			end
			if (info_take && info_idx == RPM_INFO_SER_ID)
				ser_id_r <= info_dat;
		end
	end

	// status one flags: set beats clear on read
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			lockchg_r <= 1'b0; cccrc_r <= 1'b0; ccseq_r <= 1'b0;
		end else if (ce_i) begin
			if (hit(reg_rd_i, RPM_STS_ONE)) begin
				lockchg_r <= 1'b0;
				cccrc_r   <= 1'b0;
				ccseq_r   <= 1'b0;
			end
			if (lock_chg) lockchg_r <= 1'b1;
			if (ccc_ev)   cccrc_r   <= 1'b1;
			if (ccs_ev)   ccseq_r   <= 1'b1;
		end
	end

	// parity counter: a high-byte read catches the low byte then clears
	logic par_clr;
	assign par_clr = hit(reg_rd_i, RPM_PAR_HI)
		| (lock_lost & ~gen_cfg_r[RPM_B_KEEP_PAR]);
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			par_cnt_r <= 16'h0000; parflt_r <= 1'b0;
			par_lo_hold_r <= 8'h00;
		end else if (ce_i) begin
			if (hit(reg_rd_i, RPM_PAR_HI)) par_lo_hold_r <= par_cnt_r[7:0];
			if (par_clr) begin
				par_cnt_r <= par_ev ? 16'h0001 : 16'h0000;
				parflt_r  <= par_ev && (par_thr_r <= 8'h01);
			end else if (par_ev) begin
				if (par_cnt_r != 16'hFFFF)
					par_cnt_r <= par_cnt_r + 16'h0001;
				if (par_cnt_r + 16'h0001 >= {8'h00, par_thr_r})
					parflt_r <= 1'b1;
			end
		end
	end

	// encoder fault flag, clear on read
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) encflt_r <= 1'b0;
		else if (ce_i) begin
			if (hit(reg_rd_i, RPM_STS_TWO)) encflt_r <= 1'b0;
			if (enc_rep) encflt_r <= 1'b1;
		end
	end

	// frequency measurement: link clock toggles counted per window
	logic [7:0] f_new, f_old, f_diff;
	assign f_new  = edge_cnt_r[15:8];
	assign f_old  = freq_r[15:8];
	assign f_diff = (f_new > f_old) ? f_new - f_old : f_old - f_new;
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			win_cnt_r <= 16'h0000; edge_cnt_r <= 16'h0000;
			freq_r <= 16'h0000; noclk_r <= 1'b1; steady_r <= 1'b0;
			fchg_r <= 1'b0;
		end else if (ce_i) begin
			if (hit(reg_rd_i, RPM_STS_TWO)) fchg_r <= 1'b0;
			if (win_cnt_r == 16'(FREQ_WIN_CYC - 1)) begin
				win_cnt_r  <= 16'h0000;
				edge_cnt_r <= {15'h0000, clk_ev};
				freq_r     <= edge_cnt_r;
				noclk_r    <= f_new < {4'h0, freq_ctl_r[3:0]};
				steady_r   <= f_diff <= {4'h0, freq_ctl_r[7:4]};
				if (f_diff > {4'h0, freq_ctl_r[7:4]})
					fchg_r <= 1'b1;
			end else begin
				win_cnt_r  <= win_cnt_r + 16'h0001;
				if (clk_ev && edge_cnt_r != 16'hFFFF)
					edge_cnt_r <= edge_cnt_r + 16'h0001;
			end
		end
	end

	// line count and length: held after a change while its irq is on
	logic lc_diff, ll_diff;
	assign lc_diff = frm_ev && (xf.line_cnt != lcnt_r);
	assign ll_diff = frm_ev && (xf.line_byte_length != llen_r);
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			lcnt_r <= 16'h0000; llen_r <= 16'h0000;
			lcchg_r <= 1'b0; llchg_r <= 1'b0;
		end else if (ce_i) begin
			if (hit(reg_rd_i, RPM_LCNT_LO)) lcchg_r <= 1'b0;
			if (hit(reg_rd_i, RPM_LLEN_LO)) llchg_r <= 1'b0;
			if (frm_ev && !(lcchg_r && irq_en_r[3]))
				lcnt_r <= xf.line_cnt;
			if (frm_ev && !(llchg_r && irq_en_r[4]))
				llen_r <= xf.line_byte_length;
			if (lc_diff && !(lcchg_r && irq_en_r[3])) lcchg_r <= 1'b1;
			if (ll_diff && !(llchg_r && irq_en_r[4])) llchg_r <= 1'b1;
		end
	end

	// interrupt request: level while any enabled source is pending
	logic [RPM_IRQ_W-1:0] irq_src;
	assign irq_src = {(|rise_r) | (|fall_r), llchg_r, lcchg_r, fchg_r,
		encflt_r, parflt_r};
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) irq_req_o <= 1'b0;
		else if (ce_i)
			irq_req_o <= |(irq_src & irq_en_r[RPM_IRQ_W-1:0]);
	end

	// read mux; unmapped offsets read as zero
	always_comb begin
		rdata_nxt = 8'h00;
		unique case (reg_addr_i)
			RPM_GEN_CFG:   rdata_nxt = gen_cfg_r;
			RPM_CRC_CAP:   rdata_nxt = crc_cap_r;
			RPM_IRQ_EN:    rdata_nxt = irq_en_r;
			RPM_STS_ONE:   rdata_nxt = {3'b000, lock_now, ccseq_r, cccrc_r,
				parflt_r, lockchg_r};
			RPM_STS_TWO:   rdata_nxt = {llchg_r, lcchg_r, encflt_r, 1'b0,
				fchg_r, steady_r, noclk_r, 1'b0};
			RPM_FREQ_HI:   rdata_nxt = freq_r[15:8];
			RPM_FREQ_LO:   rdata_nxt = freq_r[7:0];
			8'h51, 8'h52, 8'h53, 8'h54:
				rdata_nxt = sens_r[2'(reg_addr_i - RPM_SENS_A)];
			RPM_PAR_HI:    rdata_nxt = par_cnt_r[15:8];
			RPM_PAR_LO:    rdata_nxt = par_lo_hold_r;
			RPM_DP_ONE:    rdata_nxt = dp_one_r;
			RPM_DP_TWO:    rdata_nxt = dp_two_r;
			RPM_SER_ID:    rdata_nxt = ser_id_r;
			RPM_PAR_THR:   rdata_nxt = par_thr_r;
			RPM_LCNT_HI:   rdata_nxt = lcnt_r[15:8];
			RPM_LCNT_LO:   rdata_nxt = lcnt_r[7:0];
			RPM_LLEN_HI:   rdata_nxt = llen_r[15:8];
			RPM_LLEN_LO:   rdata_nxt = llen_r[7:0];
			RPM_FREQ_CTL:  rdata_nxt = freq_ctl_r;
			RPM_LFLT_CTL:  rdata_nxt = lflt_ctl_r;
			RPM_CRC_CTL:   rdata_nxt = crc_ctl_r;
			RPM_SENS_RISE: rdata_nxt = rise_r;
			RPM_SENS_FALL: rdata_nxt = fall_r;
			default:       rdata_nxt = 8'h00;
		endcase
	end

	// read data is registered on the read strobe
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) reg_rdata_o <= 8'h00;
		else if (ce_i && reg_rd_i) reg_rdata_o <= rdata_nxt;
	end
endmodule : rpm_port_monitor

// >>> sim/rpm_port_monitor_asserts.sv
// rpm_port_monitor_asserts: port-level checks of the status monitor.
// Assumes one system clock domain; link inputs are seen only as causes.
module rpm_port_monitor_asserts
	import rpm_pkg::*;
#(
	parameter int FREQ_WIN_CYC = RPM_FREQ_WIN_CYC
) (
	input wire logic       sys_clk_i,
	input wire logic       sys_rst_i,
	input wire logic       ce_i,
	input wire logic       lock_i,
	input wire logic [3:0] link_evt_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       irq_req_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	logic [7:0] quiet_r;  // cycles since last link event or lock edge
	logic       lock_d_r;
	logic [8:0] irq_en_r; // last irq enable write, bit 8 set = unknown
	wire  logic rd_now = ce_i && reg_rd_i;
	wire  logic wr_now = ce_i && reg_wr_i;
	wire  logic quiet  = quiet_r > 8'h28;
	always_ff @(posedge sys_clk_i) begin
		lock_d_r <= lock_i;
		if (sys_rst_i || (|link_evt_i) || lock_i != lock_d_r) quiet_r <= 8'h00;
		else if (quiet_r != 8'hFF) quiet_r <= quiet_r + 8'h01;
	end
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) irq_en_r <= 9'h100;
		else if (wr_now && reg_addr_i == RPM_IRQ_EN) irq_en_r <= {1'b0, reg_wdata_i};
	end
	sequence s_rd2(logic [7:0] a);
		quiet && rd_now && reg_addr_i == a ##1 rd_now && reg_addr_i == a;
	endsequence
	property p_unmap;
		rd_now && reg_addr_i == 8'h00 |=> reg_rdata_o == 8'h00;
	endproperty
	property p_stand;
		!rd_now |=> $stable(reg_rdata_o);
	endproperty
	property p_ctl_echo;
		wr_now && reg_addr_i == RPM_FREQ_CTL ##1 rd_now && reg_addr_i == RPM_FREQ_CTL
		|=> reg_rdata_o == $past(reg_wdata_i, 2);
	endproperty
	property p_crc_echo;
		wr_now && reg_addr_i == RPM_CRC_CTL ##1 rd_now && reg_addr_i == RPM_CRC_CTL
		|=> reg_rdata_o[7] == $past(reg_wdata_i[7], 2);
	endproperty
	property p_sts1_clr;
		s_rd2(RPM_STS_ONE) |=> reg_rdata_o[3:2] == 2'b00 && !reg_rdata_o[0];
	endproperty
	property p_par_clr;
		s_rd2(RPM_PAR_HI) |=> reg_rdata_o == 8'h00;
	endproperty
	property p_enc_clr;
		s_rd2(RPM_STS_TWO) |=> !reg_rdata_o[RPM_B_ENCFLT];
	endproperty
	property p_irq_off;
		irq_en_r == 9'h000 && $past(irq_en_r) == 9'h000 |-> !irq_req_o;
	endproperty
	a_unmap:    assert property (p_unmap) else $error("unmapped read not zero");
	a_stand:    assert property (p_stand) else $error("read data moved");
	a_ctl_echo: assert property (p_ctl_echo) else $error("freq ctl lost");
	a_crc_echo: assert property (p_crc_echo) else $error("crc ctl lost");
	a_sts1_clr: assert property (p_sts1_clr) else $error("status one stuck");
	a_par_clr:  assert property (p_par_clr) else $error("parity not cleared");
	a_enc_clr:  assert property (p_enc_clr) else $error("encoder stuck");
	a_irq_off:  assert property (p_irq_off) else $error("irq when masked");
	c_irq:  cover property (irq_req_o);
	c_par:  cover property (s_rd2(RPM_PAR_HI));
	c_freq: cover property (rd_now && reg_addr_i == RPM_FREQ_HI);
endmodule // rpm_port_monitor_asserts
bind rpm_port_monitor rpm_port_monitor_asserts #(.FREQ_WIN_CYC(FREQ_WIN_CYC))
	u_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
	.lock_i(lock_i), .link_evt_i(link_evt_i), .reg_addr_i(reg_addr_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
	.reg_rdata_o(reg_rdata_o), .irq_req_o(irq_req_o));

// >>> sim/rpm_serializer_model.sv
// rpm_serializer_model: remote serializer feeding the link-side inputs.
// Assumes one caller at a time; run=0 stops the clock.
module rpm_serializer_model (
	output logic       link_clk_o,
	output logic [3:0] evt_o,
	output logic       frame_start_o,
	output logic       line_valid_strobe_o,
	output logic       long_pkt_o,
	output logic       byte_valid_o,
	output logic       info_valid_o,
	output logic [2:0] info_idx_o,
	output logic [7:0] info_data_o,
	output logic       info_crc_ok_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic run = 1'b1; // cleared by the bench to remove the input clock
	initial begin
		{link_clk_o, evt_o, frame_start_o, line_valid_strobe_o} = '0;
		{long_pkt_o, byte_valid_o, info_valid_o} = '0;
		{info_idx_o, info_data_o, info_crc_ok_o} = 12'hA5A;
		#7.3;
		forever #24 if (run) link_clk_o = ~link_clk_o;
	end
	task automatic tick(int n);
		repeat (n) @(negedge link_clk_o);
	endtask
	task automatic pulse_evt(int i);
		tick(1);
		evt_o[i] = 1'b1;
		tick(1);
		evt_o = 4'h0;
		tick(1);
	endtask
	task automatic send_info(logic [2:0] i, logic [7:0] v, logic c);
		tick(1);
		{info_valid_o, info_idx_o, info_data_o, info_crc_ok_o} = {1'b1, i, v, c};
		tick(1);
		{info_valid_o, info_idx_o, info_data_o, info_crc_ok_o} = {1'b0, ~i, ~v, ~c};
		tick(4);
	endtask
	task automatic send_line(int nb);
		tick(1);
		{line_valid_strobe_o, long_pkt_o, byte_valid_o} = 3'h7;
		tick(1);
		long_pkt_o = 1'b0;
		tick(nb - 1);
		{line_valid_strobe_o, byte_valid_o} = 2'h0;
		tick(2);
	endtask
	task automatic frame;
		tick(1);
		frame_start_o = 1'b1;
		tick(1);
		frame_start_o = 1'b0;
		tick(2);
	endtask
endmodule // rpm_serializer_model

// >>> sim/rpm_port_monitor_bench.sv
// rpm_port_monitor_bench: register-level tests of the status monitor.
// Assumes the serializer model and checker are compiled too.
module rpm_port_monitor_bench
	import rpm_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic       sys_clk_i = 1'b0;
	logic       sys_rst_i = 1'b1;
	logic       ce_i = 1'b1;
	logic       lock_i = 1'b1;
	logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, dat, d;
	logic       reg_wr_i = 1'b0, reg_rd_i = 1'b0, irq_req_o;
	logic       lclk, fs, lv, lp, bv, iv, ok;
	logic [3:0] evt;
	logic [2:0] idx;
	int         fails = 0, n_tests = 0;
	rpm_port_monitor #(.FREQ_WIN_CYC(2560)) dut (.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i), .ce_i(ce_i), .link_clk_i(lclk), .lock_i(lock_i),
		.link_evt_i(evt), .frame_start_i(fs), .line_valid_strobe_i(lv),
		.long_pkt_i(lp), .byte_valid_i(bv), .info_valid_i(iv), .info_idx_i(idx),
		.info_data_i(dat), .info_crc_ok_i(ok), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .irq_req_o(irq_req_o));
	rpm_serializer_model p (.link_clk_o(lclk), .evt_o(evt), .frame_start_o(fs),
		.line_valid_strobe_o(lv), .long_pkt_o(lp), .byte_valid_o(bv),
		.info_valid_o(iv), .info_idx_o(idx), .info_data_o(dat),
		.info_crc_ok_o(ok));
	initial forever #4 sys_clk_i = ~sys_clk_i;
	task automatic w(int n);
		repeat (n) @(negedge sys_clk_i);
	endtask
	task automatic chk(string n, logic [7:0] s, logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] v);
		{reg_addr_i, reg_wdata_i, reg_wr_i} = {a, v, 1'b1};
		w(1);
		reg_wr_i = 1'b0;
	endtask
	task automatic rc(logic [7:0] a, logic [7:0] m, logic [7:0] e);
		{reg_addr_i, reg_rd_i} = {a, 1'b1};
		w(1);
		reg_rd_i = 1'b0;
		chk($sformatf("reg %h", a), reg_rdata_o & m, e);
	endtask
	task automatic complete_run;
		if (fails == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge sys_clk_i);
		fails++;
		complete_run();
	end
	initial begin
		w(25);
		sys_rst_i = 1'b0;
		rc(RPM_GEN_CFG, 8'hFF, RPM_GEN_CFG_RST);
		rc(RPM_CRC_CTL, 8'hFF, RPM_CRC_CTL_RST);
		rc(8'h00, 8'hFF, 8'h00);
		wr(RPM_FREQ_CTL, 8'h01);
		rc(RPM_FREQ_CTL, 8'hFF, 8'h01);
		wr(RPM_CRC_CTL, 8'h00);
		rc(RPM_CRC_CTL, 8'h80, 8'h00);
		wr(RPM_CRC_CAP, 8'h10);
		wr(RPM_IRQ_EN, 8'h00);
		wr(RPM_PAR_THR, 8'h03);
		ce_i = 1'b0;
		wr(RPM_PAR_THR, 8'h55);
		ce_i = 1'b1;
		rc(RPM_PAR_THR, 8'hFF, 8'h03);
		wr(RPM_LFLT_CTL, 8'h09);
		p.pulse_evt(0);
		p.pulse_evt(0);
		p.pulse_evt(1);
		w(50);
		rc(RPM_STS_ONE, 8'h02, 8'h00);
		rc(RPM_STS_TWO, 8'h20, 8'h00);
		rc(RPM_STS_TWO, 8'h20, 8'h00);
		p.pulse_evt(0);
		w(50);
		rc(RPM_STS_ONE, 8'h02, 8'h02);
		wr(RPM_GEN_CFG, 8'h00);
		rc(RPM_PAR_HI, 8'hFF, 8'h00);
		rc(RPM_PAR_LO, 8'hFF, 8'h03);
		wr(RPM_GEN_CFG, 8'h01);
		rc(RPM_STS_ONE, 8'h02, 8'h00);
		p.pulse_evt(0);
		p.pulse_evt(0);
		lock_i = 1'b0;
		w(20);
		lock_i = 1'b1;
		w(50);
		rc(RPM_STS_ONE, 8'h01, 8'h01);
		rc(RPM_STS_ONE, 8'h01, 8'h00);
		rc(RPM_PAR_HI, 8'hFF, 8'h00);
		rc(RPM_PAR_HI, 8'hFF, 8'h00);
		rc(RPM_PAR_LO, 8'hFF, 8'h00);
		wr(RPM_LFLT_CTL, 8'h0A);
		p.pulse_evt(1);
		p.pulse_evt(2);
		p.pulse_evt(3);
		w(50);
		rc(RPM_STS_TWO, 8'h20, 8'h20);
		rc(RPM_STS_TWO, 8'h20, 8'h00);
		rc(RPM_STS_ONE, 8'h0C, 8'h0C);
		rc(RPM_STS_ONE, 8'h0C, 8'h00);
		wr(RPM_PAR_THR, 8'h01);
		wr(RPM_IRQ_EN, 8'h01);
		p.pulse_evt(0);
		w(50);
		chk("irq", {7'h00, irq_req_o}, 8'h01);
		rc(RPM_PAR_HI, 8'hFF, 8'h00);
		w(2);
		chk("irq", {7'h00, irq_req_o}, 8'h00);
		wr(RPM_IRQ_EN, 8'h00);
		p.send_info(3'h4, 8'h5A, 1'b1);
		p.send_info(3'h4, 8'h33, 1'b0);
		p.send_info(3'h0, 8'h01, 1'b1);
		w(20);
		rc(RPM_DP_ONE, 8'hFF, 8'h5A);
		rc(RPM_SENS_A, 8'hFF, 8'h01);
		rc(RPM_SENS_RISE, 8'h01, 8'h01);
		rc(RPM_SENS_RISE, 8'h01, 8'h00);
		wr(RPM_CRC_CTL, 8'h80);
		p.send_info(3'h4, 8'h33, 1'b0);
		w(20);
		rc(RPM_DP_ONE, 8'hFF, 8'h33);
		for (int m = 0; m < 2; m++) begin
			wr(RPM_GEN_CFG, m ? 8'h05 : 8'h01);
			p.frame();
			repeat (3 - m) p.send_line(4 + m);
			p.frame();
			w(20);
			rc(RPM_LCNT_HI, 8'hFF, 8'h00);
			rc(RPM_LCNT_LO, 8'hFF, 8'(3 - m));
			rc(RPM_LLEN_HI, 8'hFF, 8'h00);
			rc(RPM_LLEN_LO, 8'hFF, 8'(4 + m));
		end
		w(5200);
		rc(RPM_STS_TWO, 8'h06, 8'h04);
		rc(RPM_FREQ_HI, 8'hFF, 8'h01);
		chk("freq", {7'h00, reg_rdata_o != 8'h00}, 8'h01);
		p.run = 1'b0;
		w(5200);
		rc(RPM_STS_TWO, 8'h0A, 8'h0A);
		p.run = 1'b1;
		w(7800);
		rc(RPM_STS_TWO, 8'h06, 8'h04);
		complete_run();
	end
endmodule // rpm_port_monitor_bench
